// ==== bp_far_side.sv ====
module bp_far_side (
    input wire logic charger,
    input wire logic load_short,
    input wire logic pack_test_pulldown,
    input wire logic pack_test_pullup,
    output logic pack_above_cell,
    output logic pack_above_supply,
    output logic pack_under_test,
    output logic pack_over_test
);
    timeunit 1ns;
    timeprecision 1ns;
    // Charger lifts pack plus over cell and supply
    assign pack_above_cell = charger;
    assign pack_above_supply = charger;
    // Test sink only wins once the charger is gone
    assign pack_under_test = pack_test_pulldown && !charger;
    // Test source only wins once the short is gone
    assign pack_over_test = pack_test_pullup && !load_short;
endmodule

// ==== bp_pkg.sv ====
package bp_pkg;

    // ==========================================================
    // Clock and timing
    // ==========================================================
    localparam int CLK_HZ = 100_000_000;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1_000;
    // Pack data line low time before disconnect sleep
    localparam int DISC_TIME_MS = 2000;
    localparam int DISC_CYCLES = DISC_TIME_MS * CYC_PER_MS;
    // Qualification delays: plain defaults, trimmed per product
    localparam int OV_DELAY_US = 1000;
    localparam int UV_DELAY_US = 1000;
    localparam int OC_DELAY_US = 100;
    localparam int SHORT_DELAY_US = 10;
    localparam int OV_DELAY_CYCLES = OV_DELAY_US * CYC_PER_US;
    localparam int UV_DELAY_CYCLES = UV_DELAY_US * CYC_PER_US;
    localparam int OC_DELAY_CYCLES = OC_DELAY_US * CYC_PER_US;
    localparam int SHORT_DELAY_CYCLES = SHORT_DELAY_US * CYC_PER_US;
    localparam int TMR_W = 32;

    // ==========================================================
    // Pin input vector (comparator and terminal levels)
    // ==========================================================
    localparam int PIN_W = 14;
    localparam int PIN_OV = 0;          // cell above overvoltage_threshold
    localparam int PIN_UV = 1;          // cell below undervoltage_threshold
    localparam int PIN_CE = 2;          // cell below charge_resume_threshold
    localparam int PIN_OC_CHG = 3;      // sense above overcurrent_threshold
    localparam int PIN_OC_DIS = 4;      // sense below -overcurrent_threshold
    localparam int PIN_DIS_80MA = 5;    // sense at or below -2 mV
    localparam int PIN_SHORT = 6;       // sense_node above short_threshold
    localparam int PIN_PLS_GT_CELL = 7;
    localparam int PIN_PLS_GT_VDD = 8;
    localparam int PIN_VDD_GT_2V2 = 9;
    localparam int PIN_PLS_LT_TEST = 10;
    localparam int PIN_PLS_GT_TEST = 11;
    localparam int PIN_DATA_LINE = 12;
    localparam int PIN_PS_N = 13;
    // Idle level: power switch released
    localparam logic [PIN_W-1:0] PIN_IDLE = 14'h2000;

    // ==========================================================
    // Register map (byte addresses)
    // ==========================================================
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REG_PROT = 4'h0;
    localparam logic [ADDR_W-1:0] REG_CONFIG = 4'h4;
    localparam logic [ADDR_W-1:0] REG_SWAP = 4'h8;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'hC;

    localparam int PROT_OV = 0;
    localparam int PROT_UV = 1;
    localparam int PROT_COC = 2;
    localparam int PROT_DOC = 3;
    localparam int PROT_CHG_ALLOW = 4;
    localparam int PROT_DIS_ALLOW = 5;
    localparam int CFG_DISC_SLEEP = 0;
    localparam int CFG_SWAP_EN = 1;
    localparam int SWAP_ENABLE_PACK = 0;

    localparam logic CHG_ALLOW_RST = 1'b1;
    localparam logic DIS_ALLOW_RST = 1'b1;
    localparam logic [1:0] CONFIG_RST = 2'h0;

    // ==========================================================
    // Qualification timer slots
    // ==========================================================
    localparam int NTMR = 6;
    localparam int T_OV = 0;
    localparam int T_UV = 1;
    localparam int T_OCC = 2;
    localparam int T_OCD = 3;
    localparam int T_SHORT = 4;
    localparam int T_DISC = 5;

    typedef enum logic {
        BP_ACTIVE = 1'b0,
        BP_SLEEP = 1'b1
    } bp_mode_e;

endpackage

// ==== bp_protect.sv ====
// Behaviour
// - Two power modes; measurement runs in active only, stops in sleep.
// - Sleep when disconnect sleep enabled and data line low over 2 s.
// - Sleep when cell stays under undervoltage threshold for its delay.
// - Sleep on swap disable command while swap enable is set.
// - Wake when disconnect sleep enabled, swap disabled, data line high.
// - Wake whenever power switch sense is pulled low.
// - Wake when pack plus exceeds cell and swap enable is clear.
// - Wake on swap enable command while swap enable is set.
// - Sleep mode after power-up.
// - Fault qualification only while active.
// - Qualified overvoltage turns charge FET off, sets overvoltage flag.
// - Overvoltage releases when cell falls under charge resume threshold.
// - Discharge stays on during overvoltage; 80 mA discharge releases early.
// - Qualified undervoltage turns both FETs off, flags, enters sleep.
// - Undervoltage releases on pack above supply, supply above 2.2 V.
// - Qualified charge overcurrent turns both FETs off, sets flag.
// - Charge overcurrent holds until pack under test level; pulldown on.
// - Discharge overcurrent turns discharge off until pack above test level.
// - Short circuit turns discharge off, sets flag, same release.
// - Discharge off on UV, overcurrent, short, allow clear or sleep.
// - Charge off on OV, UV, charge overcurrent, allow clear or sleep.
//
// Local design decisions: the placing of the registers and the Avalon-MM register port.
module bp_protect
    import bp_pkg::*;
#(
    parameter int OV_DLY = OV_DELAY_CYCLES,
    parameter int UV_DLY = UV_DELAY_CYCLES,
    parameter int OC_DLY = OC_DELAY_CYCLES,
    parameter int SHORT_DLY = SHORT_DELAY_CYCLES,
    parameter int DISC_DLY = DISC_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Comparators and terminal levels, asynchronous
    input wire logic cell_over_ov,
    input wire logic cell_under_uv,
    input wire logic cell_under_ce,
    input wire logic sense_over_oc,
    input wire logic sense_under_neg_oc,
    input wire logic sense_discharge_80ma,
    input wire logic sense_node_over_short,
    input wire logic pack_above_cell,
    input wire logic pack_above_supply,
    input wire logic supply_above_2v2,
    input wire logic pack_under_test,
    input wire logic pack_over_test,
    input wire logic pack_data_line,
    input wire logic power_switch_sense_n,
    // FET controls, high turns the FET off; then test current and measure enables, high turns them on
    output logic charge_fet_ctrl,
    output logic discharge_fet_ctrl,
    output logic pack_test_pulldown,
    output logic pack_test_pullup,
    output logic measure_en
);

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_meta;
    logic [PIN_W-1:0] pin;

    assign pin_raw = {power_switch_sense_n, pack_data_line, pack_over_test, pack_under_test,
                      supply_above_2v2, pack_above_supply, pack_above_cell, sense_node_over_short,
                      sense_discharge_80ma, sense_under_neg_oc, sense_over_oc, cell_under_ce,
                      cell_under_uv, cell_over_ov};

    // Idle vector keeps a held power switch from waking before sync settles
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_meta <= PIN_IDLE;
            pin <= PIN_IDLE;
        end else begin
            pin_meta <= pin_raw;
            pin <= pin_meta;
        end
    end

    // ==========================================================
    // State
    // ==========================================================
    bp_mode_e mode;
    bp_mode_e next_mode;
    logic ov_fault;
    logic uv_fault;
    logic coc_fault;
    logic doc_fault;
    logic overvoltage_flag;
    logic undervoltage_flag;
    logic charge_overcurrent_flag;
    logic discharge_overcurrent_flag;
    logic charge_allow;
    logic discharge_allow;
    logic disconnect_sleep_en;
    logic swap_enable;
    logic ack;

    // ==========================================================
    // Register bus decode
    // ==========================================================
    wire active = (mode == BP_ACTIVE);
    wire bus_req = read | write;
    wire bus_take = bus_req & ack;
    wire wr_take = write & ack & byteenable[0];
    wire sel_prot = (address == REG_PROT);
    wire sel_config = (address == REG_CONFIG);
    wire sel_swap = (address == REG_SWAP);
    wire sel_status = (address == REG_STATUS);
    wire wr_prot = wr_take & sel_prot;
    wire wr_config = wr_take & sel_config;
    wire wr_swap = wr_take & sel_swap & swap_enable;
    wire swap_pack_on = wr_swap & writedata[SWAP_ENABLE_PACK];
    wire swap_pack_off = wr_swap & ~writedata[SWAP_ENABLE_PACK];

    // One wait state per access, then a one-cycle release
    assign waitrequest = bus_req & ~ack;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack <= 1'b0;
        end else begin
            ack <= bus_req & ~ack;
        end
    end

    // ==========================================================
    // Qualification timers
    // ==========================================================
    logic [NTMR-1:0] qual_cond;
    logic [NTMR-1:0] qual_fire;
    logic [TMR_W-1:0] qual_lim [NTMR];

    // Comparators only count while active
    assign qual_cond[T_OV] = active & pin[PIN_OV];
    assign qual_cond[T_UV] = active & pin[PIN_UV];
    assign qual_cond[T_OCC] = active & pin[PIN_OC_CHG];
    assign qual_cond[T_OCD] = active & pin[PIN_OC_DIS];
    assign qual_cond[T_SHORT] = active & pin[PIN_SHORT];
    assign qual_cond[T_DISC] = active & disconnect_sleep_en & ~pin[PIN_DATA_LINE];

    assign qual_lim[T_OV] = TMR_W'(OV_DLY);
    assign qual_lim[T_UV] = TMR_W'(UV_DLY);
    assign qual_lim[T_OCC] = TMR_W'(OC_DLY);
    assign qual_lim[T_OCD] = TMR_W'(OC_DLY);
    assign qual_lim[T_SHORT] = TMR_W'(SHORT_DLY);
    assign qual_lim[T_DISC] = TMR_W'(DISC_DLY);

    genvar g;
    generate
        for (g = 0; g < NTMR; g++) begin : g_tmr
            logic [TMR_W-1:0] cnt;
            // Fires once the condition outlasts the delay
            assign qual_fire[g] = qual_cond[g] & (cnt == qual_lim[g]);
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    cnt <= '0;
                end else if (!qual_cond[g]) begin
                    cnt <= '0;
                end else if (cnt != qual_lim[g]) begin
                    cnt <= cnt + TMR_W'(1);
                end
            end
        end
    endgenerate

    // ==========================================================
    // Fault state and release
    // ==========================================================
    wire ov_release = pin[PIN_CE] | pin[PIN_DIS_80MA];
    wire uv_release = pin[PIN_PLS_GT_VDD] & pin[PIN_VDD_GT_2V2];
    wire coc_release = pin[PIN_PLS_LT_TEST];
    wire doc_release = pin[PIN_PLS_GT_TEST];
    wire doc_trip = qual_fire[T_OCD] | qual_fire[T_SHORT];

    // A new trip in the release cycle wins over the release
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ov_fault <= 1'b0;
            uv_fault <= 1'b0;
            coc_fault <= 1'b0;
            doc_fault <= 1'b0;
        end else begin
            ov_fault <= qual_fire[T_OV] | (ov_fault & ~ov_release);
            uv_fault <= qual_fire[T_UV] | (uv_fault & ~uv_release);
            coc_fault <= qual_fire[T_OCC] | (coc_fault & ~coc_release);
            doc_fault <= doc_trip | (doc_fault & ~doc_release);
        end
    end

    // ==========================================================
    // Sticky flags and control registers
    // ==========================================================
    wire [3:0] flag_set = {doc_trip, qual_fire[T_OCC], qual_fire[T_UV], qual_fire[T_OV]};
    wire [3:0] flag_clr = wr_prot ? writedata[PROT_DOC:PROT_OV] : 4'h0;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            overvoltage_flag <= 1'b0;
            undervoltage_flag <= 1'b0;
            charge_overcurrent_flag <= 1'b0;
            discharge_overcurrent_flag <= 1'b0;
        end else begin
            overvoltage_flag <= flag_set[0] | (overvoltage_flag & ~flag_clr[0]);
            undervoltage_flag <= flag_set[1] | (undervoltage_flag & ~flag_clr[1]);
            charge_overcurrent_flag <= flag_set[2] | (charge_overcurrent_flag & ~flag_clr[2]);
            discharge_overcurrent_flag <= flag_set[3] | (discharge_overcurrent_flag & ~flag_clr[3]);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            charge_allow <= CHG_ALLOW_RST;
            discharge_allow <= DIS_ALLOW_RST;
        end else if (wr_prot) begin
            charge_allow <= writedata[PROT_CHG_ALLOW];
            discharge_allow <= writedata[PROT_DIS_ALLOW];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {swap_enable, disconnect_sleep_en} <= CONFIG_RST;
        end else if (wr_config) begin
            disconnect_sleep_en <= writedata[CFG_DISC_SLEEP];
            swap_enable <= writedata[CFG_SWAP_EN];
        end
    end

    // ==========================================================
    // Power mode
    // ==========================================================
    wire go_sleep = qual_fire[T_DISC] | qual_fire[T_UV] | swap_pack_off;
    wire wake_connect = disconnect_sleep_en & ~swap_enable & pin[PIN_DATA_LINE];
    wire wake_switch = ~pin[PIN_PS_N];
    wire wake_charger = pin[PIN_PLS_GT_CELL] & ~swap_enable;
    wire wake = wake_connect | wake_switch | wake_charger | swap_pack_on;

    always_comb begin
        next_mode = mode;
        unique case (mode)
            BP_ACTIVE: begin
                if (go_sleep) begin
                    next_mode = BP_SLEEP;
                end
            end
            BP_SLEEP: begin
                if (wake) begin
                    next_mode = BP_ACTIVE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode <= BP_SLEEP;
        end else begin
            mode <= next_mode;
        end
    end

    // ==========================================================
    // FET and test current outputs
    // ==========================================================
    wire sleeping = (mode == BP_SLEEP);
    // Overvoltage leaves discharge alone
    wire next_dis_off = uv_fault | coc_fault | doc_fault | ~discharge_allow | sleeping;
    wire next_chg_off = ov_fault | uv_fault | coc_fault | ~charge_allow | sleeping;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            charge_fet_ctrl <= 1'b1;
            discharge_fet_ctrl <= 1'b1;
            pack_test_pulldown <= 1'b0;
            pack_test_pullup <= 1'b0;
            measure_en <= 1'b0;
        end else begin
            charge_fet_ctrl <= next_chg_off;
            discharge_fet_ctrl <= next_dis_off;
            pack_test_pulldown <= coc_fault;
            pack_test_pullup <= doc_fault;
            measure_en <= (next_mode == BP_ACTIVE);
        end
    end

    // ==========================================================
    // Read data
    // ==========================================================
    wire [31:0] rd_prot = {26'h0, discharge_allow, charge_allow, discharge_overcurrent_flag,
                           charge_overcurrent_flag, undervoltage_flag, overvoltage_flag};
    wire [31:0] rd_config = {30'h0, swap_enable, disconnect_sleep_en};
    wire [31:0] rd_status = {25'h0, discharge_fet_ctrl, charge_fet_ctrl, doc_fault, coc_fault,
                             uv_fault, ov_fault, sleeping};
    wire [31:0] rd_mux = sel_prot ? rd_prot :
                         sel_config ? rd_config :
                         sel_status ? rd_status : 32'h0000_0000;

    // Captured in the wait cycle, held through the release cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            readdata <= 32'h0000_0000;
        end else if (read & ~ack) begin
            readdata <= rd_mux;
        end
    end

    // Unused bus inputs kept visible for lint
    wire unused_bus = bus_take & sel_swap & (|byteenable[3:1]);

endmodule

// ==== bp_protect_checker.sv ====
module bp_protect_checker #(
    parameter int OV_DLY = 4,
    parameter int UV_DLY = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cell_over_ov,
    input wire logic cell_under_uv,
    input wire logic cell_under_ce,
    input wire logic sense_over_oc,
    input wire logic sense_under_neg_oc,
    input wire logic sense_discharge_80ma,
    input wire logic sense_node_over_short,
    input wire logic pack_under_test,
    input wire logic pack_over_test,
    input wire logic power_switch_sense_n,
    input wire logic charge_fet_ctrl,
    input wire logic discharge_fet_ctrl,
    input wire logic pack_test_pulldown,
    input wire logic pack_test_pullup,
    input wire logic measure_en
);
    timeunit 1ns;
    timeprecision 1ns;
    // ====================
    // Helper counters
    // ====================
    // Margin of 8 covers the synchroniser and the output register
    int ov_cnt;
    int uv_cnt;
    wire ov_run = cell_over_ov && !cell_under_ce && !sense_discharge_80ma && measure_en;
    wire uv_run = cell_under_uv && measure_en;
    always_ff @(posedge clk) begin
        ov_cnt <= (!rst_n || !ov_run) ? 0 : ov_cnt + 1;
        uv_cnt <= (!rst_n || !uv_run) ? 0 : uv_cnt + 1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ====================
    // Properties
    // ====================
    a_sleep_chg_off: assert property (!measure_en && !$past(measure_en) |-> charge_fet_ctrl)
        else $error("charge on in sleep");
    a_sleep_dis_off: assert property (!measure_en && !$past(measure_en) |-> discharge_fet_ctrl)
        else $error("discharge on in sleep");
    a_ov_trip_late: assert property (ov_cnt > OV_DLY + 8 |-> charge_fet_ctrl)
        else $error("overvoltage not acted on");
    a_uv_sleep_bound: assert property (uv_cnt <= UV_DLY + 8)
        else $error("undervoltage did not sleep");
    a_pd_both_off: assert property (pack_test_pulldown && $past(pack_test_pulldown)
        |-> charge_fet_ctrl && discharge_fet_ctrl)
        else $error("fet on during charge overcurrent");
    a_pu_dis_off: assert property (pack_test_pullup && $past(pack_test_pullup) |-> discharge_fet_ctrl)
        else $error("discharge on during discharge fault");
    a_pd_release: assert property ((pack_test_pulldown && pack_under_test && !sense_over_oc) [*3]
        |-> ##[0:4] !pack_test_pulldown)
        else $error("charge overcurrent not released");
    a_pu_release: assert property ((pack_test_pullup && pack_over_test && !sense_under_neg_oc
        && !sense_node_over_short) [*3] |-> ##[0:4] !pack_test_pullup)
        else $error("discharge fault not released");
    a_ps_wake: assert property (!power_switch_sense_n [*4] |-> ##[0:3] measure_en)
        else $error("power switch did not wake");
    a_trip_active: assert property ($rose(pack_test_pulldown || pack_test_pullup) |-> $past(measure_en, 3))
        else $error("fault qualified in sleep");
endmodule

bind bp_protect bp_protect_checker #(.OV_DLY(OV_DLY), .UV_DLY(UV_DLY)) i_bp_protect_checker (
    .clk, .rst_n, .cell_over_ov, .cell_under_uv, .cell_under_ce, .sense_over_oc, .sense_under_neg_oc,
    .sense_discharge_80ma, .sense_node_over_short, .pack_under_test, .pack_over_test,
    .power_switch_sense_n, .charge_fet_ctrl, .discharge_fet_ctrl, .pack_test_pulldown,
    .pack_test_pullup, .measure_en);

// ==== tb_battery_protection_power_modes.sv ====
module tb_battery_protection_power_modes;
    import bp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int OVD = 6, UVD = 6, OCD = 5, SCD = 3, DSD = 20;
    logic clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0, waitrequest;
    logic [3:0] address = 4'h0, byteenable = 4'hF;
    logic [31:0] writedata = 32'h0000_0000, readdata, q, r;
    logic cell_over_ov = 0, cell_under_uv = 0, cell_under_ce = 0, sense_over_oc = 0;
    logic sense_under_neg_oc = 0, sense_discharge_80ma = 0, sense_node_over_short = 0;
    logic supply_above_2v2 = 0, pack_data_line = 1, power_switch_sense_n = 1, charger = 0, load_short = 0;
    logic pack_above_cell, pack_above_supply, pack_under_test, pack_over_test;
    logic charge_fet_ctrl, discharge_fet_ctrl, pack_test_pulldown, pack_test_pullup, measure_en;
    // Model state: mode, faults and flags (ov, uv, coc, doc), allow bits
    bit md = 1, ca = 1, da = 1;
    bit [3:0] flt = 4'h0, flg = 4'h0;
    int miscompares = 0, n_tests = 0, cycles = 0, fi;
    int seed = 32'h0000_2771;
    always #5 clk = ~clk;
    bp_protect #(.OV_DLY(OVD), .UV_DLY(UVD), .OC_DLY(OCD), .SHORT_DLY(SCD), .DISC_DLY(DSD)) i_bp_protect (
        .clk, .rst_n, .address, .read, .write, .byteenable, .writedata, .readdata, .waitrequest,
        .cell_over_ov, .cell_under_uv, .cell_under_ce, .sense_over_oc, .sense_under_neg_oc,
        .sense_discharge_80ma, .sense_node_over_short, .pack_above_cell, .pack_above_supply,
        .supply_above_2v2, .pack_under_test, .pack_over_test, .pack_data_line, .power_switch_sense_n,
        .charge_fet_ctrl, .discharge_fet_ctrl, .pack_test_pulldown, .pack_test_pullup, .measure_en);
    bp_far_side i_bp_far_side (.charger, .load_short, .pack_test_pulldown, .pack_test_pullup,
        .pack_above_cell, .pack_above_supply, .pack_under_test, .pack_over_test);
    // ====================
    // Tasks
    // ====================
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic run(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Holds the request until waitrequest is sampled low
    // A slave that never answers is caught by the cycle ceiling
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] rq);
        address <= a;
        writedata <= d;
        write <= w;
        read <= !w;
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        rq = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic set_pin(input int k, input logic v);
        case (k)
            0: cell_over_ov <= v;
            1: sense_over_oc <= v;
            2: sense_under_neg_oc <= v;
            3: sense_node_over_short <= v;
            default: cell_under_uv <= v;
        endcase
    endtask
    task automatic chk_all();
        logic c, d;
        // FET outputs lag a register write by one more edge
        run(1);
        c = md || flt[0] || flt[1] || flt[2] || !ca;
        d = md || flt[1] || flt[2] || flt[3] || !da;
        check("charge_fet_ctrl", 32'(charge_fet_ctrl), 32'(c));
        check("discharge_fet_ctrl", 32'(discharge_fet_ctrl), 32'(d));
        check("measure_en", 32'(measure_en), 32'(!md));
        bus(1'b0, REG_STATUS, 32'h0000_0000, q);
        check("status", q, {25'h0, d, c, flt, md});
        bus(1'b0, REG_PROT, 32'h0000_0000, q);
        check("prot", q, {26'h0, da, ca, flg});
    endtask
    task automatic final_report();
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end
    // ====================
    // Scenarios
    // ====================
    initial begin
        run(4);
        rst_n <= 1'b1;
        run(1);
        chk_all();
        bus(1'b0, REG_CONFIG, 32'h0000_0000, q);
        check("config", q, 32'h0000_0000);
        bus(1'b0, 4'h2, 32'h0000_0000, q);
        check("unmapped", q, 32'h0000_0000);
        power_switch_sense_n <= 1'b0;
        run(6);
        power_switch_sense_n <= 1'b1;
        md = 0;
        run(4);
        chk_all();
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            ca = i[0];
            da = i[1];
            wr(REG_PROT, {r[31:6], da, ca, 4'h0});
            chk_all();
        end
        byteenable <= 4'hE;
        wr(REG_PROT, 32'h0000_0000);
        byteenable <= 4'hF;
        chk_all();
        $display("test wake and allow done");
        set_pin(0, 1'b1);
        run(OVD);
        set_pin(0, 1'b0);
        run(OVD + 8);
        chk_all();
        for (int j = 0; j < 2; j++) begin
            set_pin(0, 1'b1);
            run(OVD + 10);
            flt[0] = 1'b1;
            flg[0] = 1'b1;
            chk_all();
            set_pin(0, 1'b0);
            if (j == 0) sense_discharge_80ma <= 1'b1;
            else cell_under_ce <= 1'b1;
            run(6);
            flt[0] = 1'b0;
            chk_all();
            sense_discharge_80ma <= 1'b0;
            cell_under_ce <= 1'b0;
        end
        $display("test overvoltage done");
        for (int k = 1; k < 4; k++) begin
            fi = (k == 1) ? 2 : 3;
            charger <= (k == 1);
            load_short <= (k != 1);
            set_pin(k, 1'b1);
            run(OCD + 10);
            flt[fi] = 1'b1;
            flg[fi] = 1'b1;
            chk_all();
            check("pulldown", 32'(pack_test_pulldown), 32'(k == 1));
            check("pullup", 32'(pack_test_pullup), 32'(k != 1));
            set_pin(k, 1'b0);
            run(6);
            chk_all();
            charger <= 1'b0;
            load_short <= 1'b0;
            run(6);
            flt[fi] = 1'b0;
            chk_all();
        end
        wr(REG_PROT, 32'h0000_003F);
        flg = 4'h0;
        $display("test overcurrent done");
        set_pin(4, 1'b1);
        run(UVD + 10);
        flt[1] = 1'b1;
        flg[1] = 1'b1;
        md = 1;
        chk_all();
        set_pin(4, 1'b0);
        charger <= 1'b1;
        run(6);
        md = 0;
        chk_all();
        supply_above_2v2 <= 1'b1;
        run(6);
        flt[1] = 1'b0;
        chk_all();
        charger <= 1'b0;
        $display("test undervoltage done");
        wr(REG_CONFIG, 32'h0000_0001);
        pack_data_line <= 1'b0;
        run(DSD);
        pack_data_line <= 1'b1;
        run(6);
        chk_all();
        pack_data_line <= 1'b0;
        run(DSD + 10);
        md = 1;
        chk_all();
        pack_data_line <= 1'b1;
        run(6);
        md = 0;
        chk_all();
        wr(REG_CONFIG, 32'h0000_0003);
        wr(REG_SWAP, 32'h0000_0000);
        run(4);
        md = 1;
        chk_all();
        charger <= 1'b1;
        set_pin(0, 1'b1);
        run(OVD + 10);
        set_pin(0, 1'b0);
        chk_all();
        charger <= 1'b0;
        wr(REG_SWAP, 32'h0000_0001);
        run(4);
        md = 0;
        chk_all();
        wr(REG_CONFIG, 32'h0000_0000);
        wr(REG_SWAP, 32'h0000_0000);
        run(4);
        chk_all();
        $display("test sleep and swap done");
        final_report();
    end
endmodule
